// ---- inc/charger_cfg_pkg.sv ----
`default_nettype none
package charger_cfg_pkg;
	// Register addresses on the serial register port.
	localparam logic [7:0] TOPOFF_CFG_ADDR = 8'h19;
	localparam logic [7:0] TERM_CFG_ADDR = 8'h1A;
	// Reset values of the two configuration registers.
	localparam logic [7:0] TOPOFF_CFG_RESET = 8'h32;
	localparam logic [7:0] TERM_CFG_RESET = 8'h45;
	// Field positions.
	localparam int DUR_MSB = 6;
	localparam int DUR_LSB = 4;
	localparam int ITH_MSB = 3;
	localparam int ITH_LSB = 0;
	localparam int FOLLOW_OFF_BIT = 7;
	localparam int TERMV_MSB = 4;
	localparam int TERMV_LSB = 0;
	// Clock rate and the derived count of cycles in one second.
	localparam int CLK_PERIOD_NS = 100;
	localparam int NS_PER_SEC = 1000000000;
	localparam int TICKS_PER_SEC = NS_PER_SEC / CLK_PERIOD_NS;
	// Top-off durations.
	localparam logic [12:0] SHORT_TOPOFF_SEC = 13'h001E;
	localparam int TOPOFF_STEP_MIN = 10;
	localparam int SEC_PER_MIN = 60;
	localparam logic [12:0] TOPOFF_STEP_SEC = 13'(TOPOFF_STEP_MIN * SEC_PER_MIN);
	// Current threshold decode: code 1 is base plus one step.
	localparam logic [9:0] ITH_BASE_MA = 10'h064;
	localparam logic [9:0] ITH_STEP_MA = 10'h032;
	// Termination voltage decode in millivolts.
	localparam logic [12:0] TERMV_BASE_MV = 13'h1036;
	localparam logic [12:0] TERMV_STEP_MV = 13'h000A;
	localparam logic [12:0] TERMV_MAX_MV = 13'h116C;
	// Rail follow margin, as a percentage of battery voltage.
	localparam logic [19:0] FOLLOW_PCT = 20'h00068;
	localparam logic [19:0] PCT_DIV = 20'h00064;
	// Detail status codes.
	localparam logic [3:0] DTLS_FAST_CC = 4'h1;
	localparam logic [3:0] DTLS_FAST_CV = 4'h2;
	localparam logic [3:0] DTLS_TOPOFF = 4'h3;
	localparam logic [3:0] DTLS_DONE = 4'h4;
	// Charging phases tracked by the block.
	typedef enum logic [1:0] {ST_CHARGE, ST_TOPOFF, ST_DONE} chg_state_t;
endpackage : charger_cfg_pkg
`default_nettype wire

// ---- inc/topoff_timer_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// Carries the load, abort and expiry signals of the top-off timer.
interface topoff_timer_if;
	logic start; // One-cycle pulse that loads and starts the timer.
	logic stop; // One-cycle pulse that aborts a running timer.
	logic [12:0] load_secs; // Duration in seconds, read with start.
	logic running; // High while the timer counts.
	logic expired; // One-cycle pulse when the duration has elapsed.
	modport ctrl (output start, output stop, output load_secs, input running, input expired);
	modport timer (input start, input stop, input load_secs, output running, output expired);
endinterface : topoff_timer_if
`default_nettype wire

// ---- rtl/topoff_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
// Counts whole seconds of top-off time from a cycle prescaler.
module topoff_timer import charger_cfg_pkg::*; #(
	parameter int TICKS = TICKS_PER_SEC
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	topoff_timer_if.timer tif
);
	logic [23:0] pre; // Cycles within the current second.
	logic [23:0] next_pre;
	logic [12:0] secs; // Seconds still to run.
	logic [12:0] next_secs;
	logic run;
	logic next_run;
	logic exp;
	logic next_exp;

	// Start wins over stop; the last second ends in a one-cycle expiry pulse.
	always_comb begin
		next_pre = pre;
		next_secs = secs;
		next_run = run;
		next_exp = 1'b0;
		if (tif.start) begin
			next_pre = '0;
			next_secs = tif.load_secs;
			next_run = 1'b1;
		end else if (tif.stop) begin
			next_run = 1'b0;
		end else if (run) begin
			if (pre == 24'(TICKS - 1)) begin
				next_pre = '0;
				if (secs <= 13'h0001) begin
					next_run = 1'b0;
					next_exp = 1'b1;
				end else begin
					next_secs = secs - 13'h0001;
				end
			end else begin
				next_pre = pre + 24'h000001;
			end
		end
	end

	// Registers the timer state; frozen while the clock enable is low.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			pre <= '0;
			secs <= '0;
			run <= 1'b0;
			exp <= 1'b0;
		end else if (ce_in) begin
			pre <= next_pre;
			secs <= next_secs;
			run <= next_run;
			exp <= next_exp;
		end
	end

	assign tif.running = run;
	assign tif.expired = exp;
endmodule : topoff_timer
`default_nettype wire

// ---- rtl/charger_topoff_cv_config.sv ----
// Operation
// - Duration code 0 is 30 s, else 10-minute steps.
// - Threshold code 0 disables; 150 mA plus 50 mA steps.
// - In constant voltage, enter top-off at threshold.
// - Top-off entry raises change interrupt and status.
// - Top-off entry starts timer with selected duration.
// - Rail follows the larger of battery plus 4% and minimum rail, or termination voltage.
// - Rail following continues in the done state.
// - Termination voltage 4.15 V plus 10 mV steps.
`timescale 1ns/1ps
`default_nettype none
module charger_topoff_cv_config import charger_cfg_pkg::*; #(
	parameter int TICKS = TICKS_PER_SEC // Cycles per second of top-off time.
) (
	input wire logic core_clk_in,
	input wire logic rst_in,
	input wire logic ce_in, // Freezes all state while low.
	input wire logic reg_wr_en_in, // Register write strobe.
	input wire logic reg_rd_en_in, // Register read strobe.
	input wire logic [7:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic charger_on_in, // Charger enabled with a valid input.
	input wire logic cv_mode_in, // Fast charge is in constant-voltage regulation.
	input wire logic [12:0] charge_current_ma_in,
	input wire logic [12:0] vbatt_mv_in,
	input wire logic [12:0] vminsys_mv_in,
	output logic [7:0] reg_rdata_out,
	output logic charger_change_irq_out,
	output logic [3:0] charger_detail_status_out,
	output logic sysrail_follow_off_out,
	output logic [12:0] termination_voltage_mv_out,
	output logic [12:0] rail_target_mv_out
);
	logic [7:0] topoff_config; // Spare bit, duration, threshold.
	logic [7:0] next_topoff_config;
	logic [7:0] termination_voltage_config; // Follow-off, spare pair, voltage.
	logic [7:0] next_termination_voltage_config;
	logic [7:0] next_rdata;
	chg_state_t state;
	chg_state_t next_state;
	logic next_irq;
	logic [3:0] next_status;
	logic timer_start;
	logic next_timer_start;
	logic timer_stop;
	logic next_timer_stop;
	logic [2:0] topoff_duration_sel;
	logic [3:0] topoff_current_thresh;
	logic [4:0] termination_voltage_sel;
	logic [9:0] thresh_ma; // Decoded top-off current threshold.
	logic [12:0] duration_secs; // Decoded top-off duration.
	logic [12:0] term_mv; // Decoded termination voltage.
	logic [19:0] vbatt_pct; // Battery voltage scaled by the follow margin.
	logic [12:0] follow_mv; // Larger of scaled battery and minimum rail.
	logic [12:0] next_rail_mv;
	logic topoff_hit;
	topoff_timer_if tif ();

	assign topoff_duration_sel = topoff_config[DUR_MSB:DUR_LSB];
	assign topoff_current_thresh = topoff_config[ITH_MSB:ITH_LSB];
	assign termination_voltage_sel = termination_voltage_config[TERMV_MSB:TERMV_LSB];

	// Decodes the fields; spare bits feed none of these terms.
	always_comb begin
		if (topoff_duration_sel == 3'h0) begin
			duration_secs = SHORT_TOPOFF_SEC;
		end else begin
			duration_secs = 13'(topoff_duration_sel * TOPOFF_STEP_SEC);
		end
		thresh_ma = 10'(ITH_BASE_MA + topoff_current_thresh * ITH_STEP_MA);
		term_mv = 13'(TERMV_BASE_MV + termination_voltage_sel * TERMV_STEP_MV);
		vbatt_pct = (20'(vbatt_mv_in) * FOLLOW_PCT) / PCT_DIV;
		if (vbatt_pct[12:0] > vminsys_mv_in) begin
			follow_mv = vbatt_pct[12:0];
		end else begin
			follow_mv = vminsys_mv_in;
		end
		// Code 0 disables the threshold, so top-off is never entered on current.
		topoff_hit = cv_mode_in && (topoff_current_thresh != 4'h0)
			&& (charge_current_ma_in <= 13'(thresh_ma));
	end

	// Register port: full-byte writes, registered reads, zero for unmapped.
	always_comb begin
		next_topoff_config = topoff_config;
		next_termination_voltage_config = termination_voltage_config;
		next_rdata = reg_rdata_out;
		if (reg_wr_en_in && reg_addr_in == TOPOFF_CFG_ADDR) begin
			next_topoff_config = reg_wdata_in;
		end
		if (reg_wr_en_in && reg_addr_in == TERM_CFG_ADDR) begin
			next_termination_voltage_config = reg_wdata_in;
		end
		if (reg_rd_en_in) begin
			case (reg_addr_in)
				TOPOFF_CFG_ADDR: next_rdata = topoff_config;
				TERM_CFG_ADDR: next_rdata = termination_voltage_config;
				default: next_rdata = 8'h00;
			endcase
		end
	end

	// Stores the registers and the read data.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			topoff_config <= TOPOFF_CFG_RESET;
			termination_voltage_config <= TERM_CFG_RESET;
			reg_rdata_out <= 8'h00;
		end else if (ce_in) begin
			topoff_config <= next_topoff_config;
			termination_voltage_config <= next_termination_voltage_config;
			reg_rdata_out <= next_rdata;
		end
	end

	// Charging phase sequencer with interrupt, status and timer control.
	always_comb begin
		next_state = state;
		next_irq = 1'b0;
		next_timer_start = 1'b0;
		next_timer_stop = 1'b0;
		case (state)
			ST_CHARGE: begin
				if (charger_on_in && topoff_hit) begin
					next_state = ST_TOPOFF;
					next_irq = 1'b1;
					next_timer_start = 1'b1;
				end
			end
			ST_TOPOFF: begin
				if (!charger_on_in) begin
					next_state = ST_CHARGE;
					next_timer_stop = 1'b1;
				end else if (tif.expired) begin
					next_state = ST_DONE;
					next_irq = 1'b1;
				end
			end
			ST_DONE: begin
				if (!charger_on_in) begin
					next_state = ST_CHARGE;
				end
			end
			default: next_state = ST_CHARGE;
		endcase
		case (next_state)
			ST_TOPOFF: next_status = DTLS_TOPOFF;
			ST_DONE: next_status = DTLS_DONE;
			default: next_status = cv_mode_in ? DTLS_FAST_CV : DTLS_FAST_CC;
		endcase
		// Following does not look at the phase, so it also holds when done.
		if (termination_voltage_config[FOLLOW_OFF_BIT]) begin
			next_rail_mv = term_mv;
		end else begin
			next_rail_mv = follow_mv;
		end
	end

	// Registers the phase and all derived outputs.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= ST_CHARGE;
			charger_change_irq_out <= 1'b0;
			charger_detail_status_out <= DTLS_FAST_CC;
			timer_start <= 1'b0;
			timer_stop <= 1'b0;
			sysrail_follow_off_out <= 1'b0;
			termination_voltage_mv_out <= TERMV_BASE_MV;
			rail_target_mv_out <= TERMV_BASE_MV;
		end else if (ce_in) begin
			state <= next_state;
			charger_change_irq_out <= next_irq;
			charger_detail_status_out <= next_status;
			timer_start <= next_timer_start;
			timer_stop <= next_timer_stop;
			sysrail_follow_off_out <= termination_voltage_config[FOLLOW_OFF_BIT];
			termination_voltage_mv_out <= term_mv;
			rail_target_mv_out <= next_rail_mv;
		end
	end

	assign tif.start = timer_start;
	assign tif.stop = timer_stop;
	assign tif.load_secs = duration_secs;

	// Second-based top-off timer.
	topoff_timer #(.TICKS(TICKS)) u_timer (
		.core_clk_in(core_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.tif(tif.timer)
	);

	// A top-off entry is a charging cycle followed by a top-off cycle.
	sequence topoff_entry_s;
		state == ST_CHARGE ##1 state == ST_TOPOFF;
	endsequence

	// A write to the top-off register with the clock enabled.
	sequence topoff_write_s;
		ce_in && reg_wr_en_in && reg_addr_in == TOPOFF_CFG_ADDR;
	endsequence

	duration_decode_a: assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in)
		timer_start |-> tif.load_secs == ((topoff_duration_sel == 3'h0) ? 13'h001E
			: 13'(topoff_duration_sel * 13'h0258)))
		else $error("Top-off duration decoded wrongly.");

	thresh_disable_a: assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in)
		state == ST_CHARGE && topoff_current_thresh == 4'h0 |=> state != ST_TOPOFF)
		else $error("Top-off entered with the threshold disabled.");

	cv_entry_a: assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in)
		state == ST_CHARGE && charger_on_in && cv_mode_in && topoff_current_thresh != 4'h0
		&& charge_current_ma_in <= 13'(13'h0064 + topoff_current_thresh * 13'h0032)
		|=> state == ST_TOPOFF)
		else $error("Top-off not entered at the threshold.");

	entry_irq_a: assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in)
		topoff_entry_s |-> charger_change_irq_out && charger_detail_status_out == DTLS_TOPOFF)
		else $error("Top-off entry without interrupt or status.");

	timer_start_a: assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in)
		topoff_entry_s ##1 ce_in |=> tif.running)
		else $error("Top-off timer not running after entry.");

	follow_off_a: assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in)
		termination_voltage_config[FOLLOW_OFF_BIT] |=> rail_target_mv_out == $past(term_mv))
		else $error("Rail not at termination voltage.");

	done_follow_a: assert property (@(posedge core_clk_in) disable iff (rst_in || !ce_in)
		state == ST_DONE && !termination_voltage_config[FOLLOW_OFF_BIT]
		|=> rail_target_mv_out >= $past(vminsys_mv_in) && rail_target_mv_out >= $past(vbatt_mv_in))
		else $error("Rail stopped following the battery when done.");

	termv_range_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		termination_voltage_mv_out >= TERMV_BASE_MV && termination_voltage_mv_out <= TERMV_MAX_MV
		&& (termination_voltage_mv_out - TERMV_BASE_MV) % 13'h000A == 13'h0000)
		else $error("Termination voltage outside its decode.");

	spare_keep_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
		topoff_write_s |=> topoff_config == $past(reg_wdata_in))
		else $error("Top-off register did not keep the written byte.");
endmodule : charger_topoff_cv_config
`default_nettype wire

// ---- bench/host_port_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Host side of the register port: single-byte writes and reads on plain strobes.
module host_port_model (
	input wire logic core_clk_in,
	input wire logic [7:0] reg_rdata_in,
	output logic reg_wr_en_out,
	output logic reg_rd_en_out,
	output logic [7:0] reg_addr_out,
	output logic [7:0] reg_wdata_out
);
	// Idle at time zero, so no request is made while reset holds.
	initial begin
		reg_wr_en_out = 1'b0;
		reg_rd_en_out = 1'b0;
		reg_addr_out = 8'h00;
		reg_wdata_out = 8'h00;
	end
	// Holds the strobe for one edge, then drives inverted lines so stale values never match.
	task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
		@(posedge core_clk_in);
		#10;
		reg_addr_out = addr;
		reg_wdata_out = data;
		reg_wr_en_out = 1'b1;
		@(posedge core_clk_in);
		#10;
		reg_wr_en_out = 1'b0;
		reg_addr_out = ~addr;
		reg_wdata_out = ~data;
	endtask : write_reg
	// Read data is registered and holds until the next read, so it is taken one edge later.
	task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
		@(posedge core_clk_in);
		#10;
		reg_addr_out = addr;
		reg_rd_en_out = 1'b1;
		@(posedge core_clk_in);
		#10;
		reg_rd_en_out = 1'b0;
		reg_addr_out = ~addr;
		@(posedge core_clk_in);
		#10;
		data = reg_rdata_in;
	endtask : read_reg
endmodule : host_port_model
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the top-off and termination voltage configuration block.
module tb_top import charger_cfg_pkg::*;;
	localparam int TB_TICKS = 4; // A short second keeps every top-off run brief.
	logic core_clk = 1'b0; // 10 MHz core clock.
	logic rst = 1'b1; // Held for the first 20 cycles.
	logic ce = 1'b1; // Clock enable, lowered once to show a frozen port.
	logic chg_on = 1'b0; // Charger enabled.
	logic cv = 1'b0; // Constant-voltage regulation.
	logic [12:0] cur = 13'h1FFF; // Charge current in mA.
	logic [12:0] vbat = 13'h0E10; // Battery voltage in mV.
	logic [12:0] vmin = 13'h0DAC; // Minimum rail voltage in mV.
	logic wr_en, rd_en, irq, follow_off;
	logic [7:0] addr, wdata, rdata, v, rd;
	logic [3:0] dtls;
	logic [12:0] term_mv, rail_mv;
	int miscompares = 0;
	int compares = 0;
	// Free-running clock.
	always #50 core_clk = ~core_clk;
	host_port_model host (.core_clk_in(core_clk), .reg_rdata_in(rdata), .reg_wr_en_out(wr_en),
		.reg_rd_en_out(rd_en), .reg_addr_out(addr), .reg_wdata_out(wdata));
	charger_topoff_cv_config #(.TICKS(TB_TICKS)) i_charger_topoff_cv_config (
		.core_clk_in(core_clk), .rst_in(rst), .ce_in(ce), .reg_wr_en_in(wr_en),
		.reg_rd_en_in(rd_en), .reg_addr_in(addr), .reg_wdata_in(wdata), .charger_on_in(chg_on),
		.cv_mode_in(cv), .charge_current_ma_in(cur), .vbatt_mv_in(vbat), .vminsys_mv_in(vmin),
		.reg_rdata_out(rdata), .charger_change_irq_out(irq), .charger_detail_status_out(dtls),
		.sysrail_follow_off_out(follow_off), .termination_voltage_mv_out(term_mv),
		.rail_target_mv_out(rail_mv));
	// Rail target: termination voltage, or the larger of battery plus 4% and minimum rail.
	function automatic logic [15:0] exp_rail(input logic off, input logic [4:0] code);
		int t;
		t = vbat * 104 / 100;
		if (off) begin
			return 16'(4150 + 10 * code);
		end
		return 16'((t > vmin) ? t : vmin);
	endfunction : exp_rail
	// Compares one value and counts the outcome.
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	// Lets n edges pass and lands just after the last one.
	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#10;
	endtask : cyc
	// Prints the counts and the verdict, then ends the run.
	task automatic finish_test();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : finish_test
	// One constant-voltage decay into top-off, then timer expiry into done.
	task automatic topoff_run(input logic [2:0] d, input logic [3:0] t);
		int n;
		int base;
		base = ((d == 3'h0) ? 30 : 600 * d) * TB_TICKS;
		host.write_reg(TOPOFF_CFG_ADDR, {1'($urandom), d, t});
		chg_on = 1'b1;
		cv = 1'b1;
		cur = 13'(100 + 50 * t + 1);
		cyc(4);
		check("above_thresh", 16'(dtls), 16'(DTLS_FAST_CV));
		cur = 13'(100 + 50 * t);
		n = 0;
		while (irq !== 1'b1 && n < 4) begin
			cyc(1);
			n++;
		end
		check("irq_entry", 16'(irq), 16'h0001);
		check("status_topoff", 16'(dtls), 16'(DTLS_TOPOFF));
		cyc(1);
		check("irq_pulse", 16'(irq), 16'h0000);
		n = 0;
		while (dtls !== DTLS_DONE && n < base + 6) begin
			cyc(1);
			n++;
		end
		check("topoff_len", 16'(n >= base - 1 && n <= base + 4), 16'h0001);
		check("irq_done", 16'(irq), 16'h0001);
		vbat = 13'($urandom_range(4400, 3000));
		cyc(3);
		check("rail_done", 16'(rail_mv), exp_rail(1'b0, 5'h05));
		chg_on = 1'b0;
		cv = 1'b0;
		cyc(3);
		check("status_cc", 16'(dtls), 16'(DTLS_FAST_CC));
	endtask : topoff_run
	// Main sequence.
	initial begin
		void'($urandom(32'hDC8CCA88));
		repeat (20) @(posedge core_clk);
		#10;
		rst = 1'b0;
		check("status_reset", 16'(dtls), 16'(DTLS_FAST_CC));
		host.read_reg(TOPOFF_CFG_ADDR, rd);
		check("topoff_reset", 16'(rd), 16'(TOPOFF_CFG_RESET));
		host.read_reg(TERM_CFG_ADDR, rd);
		check("term_reset", 16'(rd), 16'(TERM_CFG_RESET));
		// Every termination code, with random spare and follow bits.
		for (int c = 0; c < 32; c++) begin
			v = {1'($urandom), 2'($urandom), 5'(c)};
			host.write_reg(TERM_CFG_ADDR, v);
			vbat = 13'($urandom_range(4400, 3000));
			vmin = 13'($urandom_range(4000, 3000));
			cyc(2);
			check("term_mv", 16'(term_mv), 16'(4150 + 10 * c));
			check("follow_off", 16'(follow_off), 16'(v[7]));
			check("rail_mv", 16'(rail_mv), exp_rail(v[7], 5'(c)));
			host.read_reg(TERM_CFG_ADDR, rd);
			check("term_rb", 16'(rd), 16'(v));
		end
		// Random readback of the top-off register, spare bit included.
		repeat (8) begin
			v = 8'($urandom);
			host.write_reg(TOPOFF_CFG_ADDR, v);
			host.read_reg(TOPOFF_CFG_ADDR, rd);
			check("topoff_rb", 16'(rd), 16'(v));
		end
		ce = 1'b0;
		host.write_reg(TOPOFF_CFG_ADDR, ~v);
		ce = 1'b1;
		host.read_reg(TOPOFF_CFG_ADDR, rd);
		check("frozen_wr", 16'(rd), 16'(v));
		host.write_reg(8'h1B, 8'hA5);
		host.read_reg(8'h1B, rd);
		check("unmapped", 16'(rd), 16'h0000);
		// Threshold code 0 never enters top-off, even at zero current.
		host.write_reg(TOPOFF_CFG_ADDR, 8'h00);
		chg_on = 1'b1;
		cv = 1'b1;
		cur = 13'h0000;
		cyc(10);
		check("thresh_off", 16'(dtls), 16'(DTLS_FAST_CV));
		chg_on = 1'b0;
		cv = 1'b0;
		host.write_reg(TERM_CFG_ADDR, {1'b0, 2'($urandom), 5'h05});
		for (int d = 0; d < 8; d++) begin
			topoff_run(3'(d), 4'($urandom_range(15, 1)));
		end
		// Charger off during top-off drops back to charging without a done pulse.
		host.write_reg(TOPOFF_CFG_ADDR, {1'b0, 3'h0, 4'($urandom_range(15, 1))});
		chg_on = 1'b1;
		cv = 1'b1;
		cur = 13'h0000;
		cyc(3);
		check("abort_entry", 16'(dtls), 16'(DTLS_TOPOFF));
		chg_on = 1'b0;
		cyc(2);
		check("abort_exit", 16'(dtls), 16'(DTLS_FAST_CV));
		check("abort_irq", 16'(irq), 16'h0000);
		cv = 1'b0;
		cyc(2);
		finish_test();
	end
	// Watchdog sized above the longest expected run.
	initial begin
		#(95000 * 100);
		miscompares++;
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
